// [rtl/rtc_aux_pkg.sv]
/*
  shared constants and types of the clock-chip auxiliary logic: register
  addresses, bit positions, reset values, divider figures and carriers.
  assumes a single 25 mhz system clock and a 32.768 khz oscillator pin.
*/
package rtc_aux_pkg;
  // system and oscillator rates
  localparam int SYS_CLK_HZ = 25000000;
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = 15;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int BATT_CHECK_SECONDS = 86400;

  // register addresses as seen by the serial front end
  localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_SQW_CTRL = 8'h0a;
  localparam logic [7:0] ADDR_FLAGS = 8'h0f;
  localparam logic [7:0] ADDR_TIMER_VALUE = 8'h10;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h11;
  localparam logic [7:0] ADDR_SQW_RATE = 8'h13;

  // bit positions inside those registers
  localparam int OUT_BIT = 7;
  localparam int SQUARE_WAVE_ENABLE_BIT = 6;
  localparam int FLAG_WDF_BIT = 7;
  localparam int FLAG_AF1_BIT = 6;
  localparam int FLAG_AF2_BIT = 5;
  localparam int FLAG_BL_BIT = 4;
  localparam int FLAG_TF_BIT = 3;
  localparam int FLAG_OF_BIT = 2;
  localparam int RATE_LSB = 4;

  // values after reset
  localparam logic OUT_RST = 1'b1;
  localparam logic SQUARE_WAVE_ENABLE_RST = 1'b1;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h03;
  localparam logic [3:0] RATE_RST = 4'h1;
  localparam logic [7:0] TIMER_VALUE_RST = 8'h00;
  localparam logic [1:0] CENTURY_RST = 2'h0;

  // timer source clock codes
  localparam logic [1:0] TSRC_4096HZ = 2'h0;
  localparam logic [1:0] TSRC_64HZ = 2'h1;
  localparam logic [1:0] TSRC_1HZ = 2'h2;
  localparam logic [1:0] TSRC_60S = 2'h3;

  // pulse-mode low times as rates in hz, then in oscillator ticks
  localparam int PULSE_HZ_FAST_N1 = 8192;
  localparam int PULSE_HZ_FAST = 4096;
  localparam int PULSE_HZ_MID_N1 = 128;
  localparam int PULSE_HZ_SLOW = 64;
  localparam int PW_W = 10;
  localparam logic [PW_W-1:0] PW_FAST_N1 = PW_W'(OSC_HZ / PULSE_HZ_FAST_N1);
  localparam logic [PW_W-1:0] PW_FAST = PW_W'(OSC_HZ / PULSE_HZ_FAST);
  localparam logic [PW_W-1:0] PW_MID_N1 = PW_W'(OSC_HZ / PULSE_HZ_MID_N1);
  localparam logic [PW_W-1:0] PW_SLOW = PW_W'(OSC_HZ / PULSE_HZ_SLOW);

  // timer control register layout
  typedef struct packed {
    logic run_en;
    logic pulse_sel;
    logic irq_en;
    logic [2:0] unused;
    logic [1:0] clk_sel;
  } timer_ctrl_t;

  // one-cycle ticks of the four timer sources
  typedef struct packed {
    logic tick_4096;
    logic tick_64;
    logic tick_1;
    logic tick_60s;
  } src_ticks_t;

  // flags kept by the alarm, watchdog and oscillator-check logic
  typedef struct packed {
    logic wdf;
    logic af1;
    logic af2;
    logic osc_fail;
  } ext_flags_t;

  // battery check sequencer
  typedef enum logic [1:0] {
    BAT_OFF = 2'b00,
    BAT_SAMPLE = 2'b01,
    BAT_WAIT = 2'b11
  } bat_state_t;
endpackage

// [rtl/osc_divider.sv]
/*
  oscillator divider chain: synchronises the 32.768 khz pin, counts its
  rising edges and derives the four timer source ticks.
  assumes the oscillator is far slower than sys_clk.
*/
`timescale 1ns/1ps
module osc_divider
  import rtc_aux_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // oscillator pin
  input wire logic osc_32k,
  // divided outputs
  output logic osc_level,
  output logic osc_tick,
  output logic [DIV_W-1:0] div_cnt,
  output src_ticks_t ticks
);
  logic osc_meta_r; // first synchroniser stage
  logic osc_sync_r; // second synchroniser stage
  logic osc_prev_r; // for edge detection
  logic [DIV_W-1:0] div_r; // ripple-free binary divider
  logic [5:0] sec_cnt_r; // seconds toward one minute
  logic edge_w;

  // two-stage synchroniser, then an edge detector on the settled level
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_32k;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  assign edge_w = osc_sync_r & ~osc_prev_r;

  // divider count advances once per oscillator period
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_r <= '0;
    end else if (edge_w) begin
      div_r <= div_r + 1'b1;
    end
  end

  // minute prescaler counts the 1 hz ticks
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sec_cnt_r <= '0;
    end else if (edge_w && (&div_r)) begin
      if (sec_cnt_r == 6'(SECONDS_PER_MINUTE - 1)) begin
        sec_cnt_r <= '0;
      end else begin
        sec_cnt_r <= sec_cnt_r + 1'b1;
      end
    end
  end

  assign osc_level = osc_sync_r;
  assign osc_tick = edge_w;
  assign div_cnt = div_r;
  // each source fires when its slice of the divider wraps
  assign ticks.tick_4096 = edge_w & (&div_r[2:0]);
  assign ticks.tick_64 = edge_w & (&div_r[8:0]);
  assign ticks.tick_1 = edge_w & (&div_r);
  assign ticks.tick_60s = edge_w & (&div_r) & (sec_cnt_r == 6'(SECONDS_PER_MINUTE - 1));
endmodule

// [rtl/rtc_aux_timer.sv]
/*
  auxiliary logic of a serial-bus clock chip: countdown timer with flag and
  level or pulse interrupt, combined open-drain interrupt/output pin,
  square-wave generator, battery-low check and century counter.
  assumes a serial front end that decodes bus cycles into one-cycle
  register strobes on sys_clk, and alarm/watchdog/oscillator logic elsewhere.
*/
`timescale 1ns/1ps
// Summary of operation
// - level mode: flag and enable assert pin
// - pulse mode: timed pulses, width per source
// - other sources keep pin low in pulse mode
// - pulses stop only when enables cleared
// - flag and pin activate together
// - expiry sets flag, reloads, keeps counting
// - reading flags register clears timer flag
// - level interrupt released by flag/enable clear
// - load value zero stops timer
// - runs only when enabled; cleared at power-down
// - two-bit field selects timer source clock
// - period equals load over source rate
// - value write keeps flag and interrupt
// - rate field picks square-wave frequency
// - square wave only while its enable set
// - supply loss disables square wave
// - battery tested at power-up and daily
// - battery-low flag held until passing test
// - battery tested only on main supply
// - century counter and leap-year rule
// - no sources enabled: pin follows static bit
// - timer controls live at 11h
// - timer flag at bit 3 of flags
// - pulse select picks pulse or level
module rtc_aux_timer
  import rtc_aux_pkg::*;
#(
  parameter int BATT_CHECK_S = BATT_CHECK_SECONDS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register strobes from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic flags_read,
  // oscillator and supply pins
  input wire logic osc_32k,
  input wire logic vcc_nominal,
  input wire logic battery_ok,
  // other interrupt sources and their enables
  input ext_flags_t ext_flags,
  input wire logic alarm1_irq_active,
  input wire logic watchdog_irq_active,
  input wire logic osc_fail_irq_active,
  input wire logic alarm1_irq_enable,
  input wire logic osc_fail_irq_enable,
  input wire logic watchdog_armed,
  // calendar hooks
  input wire logic century_rollover,
  input wire logic [7:0] year_bcd,
  output logic [1:0] century_count,
  output logic leap_year,
  // pins
  output logic irq_pin_combined_o,
  output logic irq_pin_combined_oe,
  output logic square_wave_pin
);
  logic osc_level; // synchronised oscillator level
  logic osc_tick; // one cycle per oscillator period
  logic [DIV_W-1:0] div_cnt; // divider chain value
  src_ticks_t ticks; // timer source ticks
  timer_ctrl_t ctrl_r; // timer control register
  logic [7:0] reload_r; // loaded value n
  logic [7:0] count_r; // running countdown
  logic timer_expired_flag_r; // sticky timer flag
  logic battery_low_flag_r; // battery-low flag
  logic out_bit_r; // static level of the pin
  logic square_wave_enable_r; // square-wave enable
  logic [3:0] square_rate_select_r; // square-wave rate code
  logic [PW_W-1:0] pulse_cnt_r; // remaining pulse low time
  logic square_r; // registered square-wave pin
  logic [1:0] century_count_r; // century counter
  logic leap_r; // registered leap-year answer
  logic [7:0] rdata_r; // read data
  logic vcc_meta_r, vcc_s, vcc_prev_r; // supply sense synchroniser
  logic bat_meta_r, bat_s; // battery comparator synchroniser
  bat_state_t bat_state_r;
  logic [16:0] day_cnt_r; // seconds since last battery check
  logic src_tick, expire, rd_flags, wr_value, wr_ctrl;
  logic pulse_run, timer_level_irq, timer_pulse_irq, static_low, any_src_en;
  logic irq_low;

  osc_divider u_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .osc_32k(osc_32k),
    .osc_level(osc_level),
    .osc_tick(osc_tick),
    .div_cnt(div_cnt),
    .ticks(ticks)
  );

  // picks the tick of the selected source clock
  function automatic logic pick_tick(input src_ticks_t t, input logic [1:0] sel);
    case (sel)
      TSRC_4096HZ: pick_tick = t.tick_4096;
      TSRC_64HZ: pick_tick = t.tick_64;
      TSRC_1HZ: pick_tick = t.tick_1;
      default: pick_tick = t.tick_60s;
    endcase
  endfunction

  // pulse low time in oscillator ticks, shorter for a load of one on the 4096 hz and 64 hz sources
  function automatic logic [PW_W-1:0] pulse_width(input logic [1:0] sel, input logic n_is_one);
    case (sel)
      TSRC_4096HZ: pulse_width = n_is_one ? PW_FAST_N1 : PW_FAST;
      TSRC_64HZ: pulse_width = n_is_one ? PW_MID_N1 : PW_SLOW;
      default: pulse_width = PW_SLOW;
    endcase
  endfunction

  // year in bcd divisible by four
  function automatic logic bcd_div4(input logic [7:0] y);
    if (y[4]) begin
      bcd_div4 = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      bcd_div4 = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  // supply and battery pins come from outside: two stages before use
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      vcc_meta_r <= 1'b0;
      vcc_s <= 1'b0;
      vcc_prev_r <= 1'b0;
      bat_meta_r <= 1'b0;
      bat_s <= 1'b0;
    end else begin
      vcc_meta_r <= vcc_nominal;
      vcc_s <= vcc_meta_r;
      vcc_prev_r <= vcc_s;
      bat_meta_r <= battery_ok;
      bat_s <= bat_meta_r;
    end
  end

  assign rd_flags = reg_rd && (reg_addr == ADDR_FLAGS);
  assign wr_value = reg_wr && (reg_addr == ADDR_TIMER_VALUE);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_TIMER_CTRL);
  assign flags_read = rd_flags;
  // a zero load value or a cleared run bit freezes the count
  assign src_tick = pick_tick(ticks, ctrl_r.clk_sel);
  assign expire = src_tick && ctrl_r.run_en && (reload_r != 8'h00) && (count_r <= 8'h01);

  // timer control; a supply loss wins over a host write
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= timer_ctrl_t'(TIMER_CTRL_RST);
    end else if (vcc_prev_r && !vcc_s) begin
      ctrl_r.run_en <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_r <= timer_ctrl_t'({reg_wdata[7:5], 3'h0, reg_wdata[1:0]});
    end
  end

  // countdown: n source ticks per period, then auto reload
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reload_r <= TIMER_VALUE_RST;
      count_r <= TIMER_VALUE_RST;
    end else if (wr_value) begin
      reload_r <= reg_wdata;
      count_r <= reg_wdata;
    end else if (expire) begin
      count_r <= reload_r;
    end else if (src_tick && ctrl_r.run_en && (reload_r != 8'h00)) begin
      count_r <= count_r - 8'h01;
    end
  end

  // timer flag: expiry in the read cycle still sets it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timer_expired_flag_r <= 1'b0;
    end else if (expire) begin
      timer_expired_flag_r <= 1'b1;
    end else if (rd_flags) begin
      timer_expired_flag_r <= 1'b0;
    end
  end

  // pulse generator; it ignores the flag, so clearing it does not stop pulses
  assign pulse_run = ctrl_r.run_en && ctrl_r.irq_en && ctrl_r.pulse_sel;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pulse_cnt_r <= '0;
    end else if (!pulse_run) begin
      pulse_cnt_r <= '0;
    end else if (expire) begin
      pulse_cnt_r <= pulse_width(ctrl_r.clk_sel, reload_r == 8'h01);
    end else if (osc_tick && (pulse_cnt_r != '0)) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  // static output, square-wave enable and rate registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_bit_r <= OUT_RST;
    end else if (reg_wr && (reg_addr == ADDR_OUTPUT_CTRL)) begin
      out_bit_r <= reg_wdata[OUT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      square_wave_enable_r <= SQUARE_WAVE_ENABLE_RST;
      square_rate_select_r <= RATE_RST;
    end else if (reg_wr && (reg_addr == ADDR_SQW_CTRL)) begin
      square_wave_enable_r <= reg_wdata[SQUARE_WAVE_ENABLE_BIT];
    end else if (reg_wr && (reg_addr == ADDR_SQW_RATE)) begin
      square_rate_select_r <= reg_wdata[RATE_LSB +: 4];
    end
  end

  // code 1 is the oscillator itself; code k>1 is 32768 >> k
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      square_r <= 1'b0;
    end else if (!square_wave_enable_r || !vcc_s) begin
      square_r <= 1'b0;
    end else begin
      case (square_rate_select_r)
        4'h0: square_r <= 1'b0;
        4'h1: square_r <= osc_level;
        default: square_r <= div_cnt[square_rate_select_r - 4'h1];
      endcase
    end
  end

  // battery check sequencer, idle while on back-up
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bat_state_r <= BAT_OFF;
      day_cnt_r <= '0;
      battery_low_flag_r <= 1'b0;
    end else begin
      case (bat_state_r)
        BAT_OFF: begin
          day_cnt_r <= '0;
          if (vcc_s) begin
            bat_state_r <= BAT_SAMPLE;
          end
        end
        BAT_SAMPLE: begin
          battery_low_flag_r <= !bat_s;
          day_cnt_r <= '0;
          bat_state_r <= vcc_s ? BAT_WAIT : BAT_OFF;
        end
        BAT_WAIT: begin
          if (!vcc_s) begin
            bat_state_r <= BAT_OFF;
          end else if (ticks.tick_1) begin
            if (day_cnt_r == 17'(BATT_CHECK_S - 1)) begin
              bat_state_r <= BAT_SAMPLE;
            end else begin
              day_cnt_r <= day_cnt_r + 17'h00001;
            end
          end
        end
        default: bat_state_r <= BAT_OFF;
      endcase
    end
  end

  // century counter wraps in binary; leap answer registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      century_count_r <= CENTURY_RST;
      leap_r <= 1'b0;
    end else begin
      if (century_rollover) begin
        century_count_r <= century_count_r + 2'h1;
      end
      leap_r <= bcd_div4(year_bcd) && ((year_bcd != 8'h00) || (century_count_r == 2'h0));
    end
  end

  // read data, captured on the read strobe, unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_OUTPUT_CTRL: rdata_r <= {out_bit_r, 7'h00};
        ADDR_SQW_CTRL: rdata_r <= {1'b0, square_wave_enable_r, 6'h00};
        ADDR_FLAGS: rdata_r <= {ext_flags.wdf, ext_flags.af1, ext_flags.af2, battery_low_flag_r,
                                timer_expired_flag_r, ext_flags.osc_fail, 2'h0};
        ADDR_TIMER_VALUE: rdata_r <= count_r;
        ADDR_TIMER_CTRL: rdata_r <= ctrl_r;
        ADDR_SQW_RATE: rdata_r <= {square_rate_select_r, 4'h0};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // combined pin: any active source pulls the open-drain line low
  assign timer_level_irq = timer_expired_flag_r && ctrl_r.irq_en && !ctrl_r.pulse_sel;
  assign timer_pulse_irq = pulse_run && (pulse_cnt_r != '0);
  assign any_src_en = osc_fail_irq_enable || alarm1_irq_enable || watchdog_armed;
  assign static_low = !any_src_en && !out_bit_r;
  assign irq_low = timer_level_irq || timer_pulse_irq || alarm1_irq_active || watchdog_irq_active
                   || osc_fail_irq_active || static_low;
  assign irq_pin_combined_o = 1'b0;
  assign irq_pin_combined_oe = irq_low;
  assign square_wave_pin = square_r;
  assign century_count = century_count_r;
  assign leap_year = leap_r;
  assign reg_rdata = rdata_r;

  property p_level_irq;
    @(posedge sys_clk) disable iff (!resetn)
    (timer_expired_flag_r && ctrl_r.irq_en && !ctrl_r.pulse_sel) |-> irq_pin_combined_oe;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level timer irq not driven");

  property p_pulse_stop;
    @(posedge sys_clk) disable iff (!resetn)
    !(ctrl_r.run_en && ctrl_r.irq_en && ctrl_r.pulse_sel) |=> (pulse_cnt_r == '0);
  endproperty
  a_pulse_stop: assert property (p_pulse_stop) else $error("pulse kept after enables cleared");

  property p_flag_pin_together;
    @(posedge sys_clk) disable iff (!resetn)
    (expire && ctrl_r.irq_en && !wr_ctrl && !(vcc_prev_r && !vcc_s)) |=> (timer_expired_flag_r && irq_pin_combined_oe);
  endproperty
  a_flag_pin_together: assert property (p_flag_pin_together) else $error("flag and pin not together");

  property p_reload;
    @(posedge sys_clk) disable iff (!resetn)
    (expire && !wr_value) |=> (count_r == $past(reload_r));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at expiry");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!resetn)
    (rd_flags && !expire) |=> !timer_expired_flag_r;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read did not clear flag");

  property p_zero_stops;
    @(posedge sys_clk) disable iff (!resetn)
    ((reload_r == 8'h00 || !ctrl_r.run_en) && !wr_value) |=> ($stable(count_r) && !$past(expire));
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("stopped timer moved");

  property p_write_keeps_flag;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_value && !rd_flags && !expire) |=> (timer_expired_flag_r == $past(timer_expired_flag_r));
  endproperty
  a_write_keeps_flag: assert property (p_write_keeps_flag) else $error("value write changed flag");

  property p_sqw_off;
    @(posedge sys_clk) disable iff (!resetn)
    (!square_wave_enable_r || !vcc_s) |=> !square_wave_pin;
  endproperty
  a_sqw_off: assert property (p_sqw_off) else $error("square wave while disabled");

  property p_static_out;
    @(posedge sys_clk) disable iff (!resetn)
    (!osc_fail_irq_enable && !alarm1_irq_enable && !watchdog_armed && !out_bit_r) |-> irq_pin_combined_oe;
  endproperty
  a_static_out: assert property (p_static_out) else $error("static low level not driven");

  property p_power_down;
    @(posedge sys_clk) disable iff (!resetn)
    (vcc_prev_r && !vcc_s) |=> !ctrl_r.run_en;
  endproperty
  a_power_down: assert property (p_power_down) else $error("run enable kept at power-down");
endmodule

// [verif/host_model.sv]
/*
  host side model: drives the register strobes the way the serial front end
  does, one byte per call.
  assumes sys_clk from the bench and registered read data from the design.
*/
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic sys_clk,
  // register strobes
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // idle strobes from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write cycle; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read cycle; data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// [verif/rtc_aux_timer_tb.sv]
/*
  self-checking bench of rtc_aux_timer: register calls through host_model,
  checks on the pins and read data.
  assumes an oscillator made eight times slower than sys_clk to keep waits short.
*/
`timescale 1ns/1ps
module rtc_aux_timer_tb;
  import rtc_aux_pkg::*;
  logic sys_clk = 0, resetn = 0; // clock and reset
  logic reg_wr, reg_rd; // strobes from the host
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic osc_32k = 0, vcc_nominal = 1, battery_ok = 1; // pins
  logic alarm1_irq_active = 0, alarm1_irq_enable = 0, century_rollover = 0;
  logic [7:0] year_bcd = 8'h00;
  logic [2:0] oc = 3'h0; // oscillator divider
  logic [1:0] century_count;
  logic leap_year, irq_pin_combined_oe, square_wave_pin;
  logic pin_o, flags_read; // open-drain data level and flag-read strobe
  ext_flags_t xf = '0; // flags of the alarm, watchdog and oscillator logic
  int err_count = 0, checks = 0, n, cyc = 0, t0, fr = 0;
  always #20 sys_clk = ~sys_clk;
  // fast oscillator and cycle count
  always @(posedge sys_clk) begin
    oc <= oc + 3'h1;
    osc_32k <= oc[2];
    cyc <= cyc + 1;
    if (flags_read) fr <= fr + 1;
  end
  host_model host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  // short battery interval; osc-fail and watchdog sources tied off
  rtc_aux_timer #(.BATT_CHECK_S(2)) dut (.sys_clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .flags_read, .osc_32k, .vcc_nominal, .battery_ok, .ext_flags(xf),
    .alarm1_irq_active, .watchdog_irq_active(1'b0), .osc_fail_irq_active(1'b0), .alarm1_irq_enable,
    .osc_fail_irq_enable(1'b0), .watchdog_armed(1'b0), .century_rollover, .year_bcd, .century_count,
    .leap_year, .irq_pin_combined_o(pin_o), .irq_pin_combined_oe, .square_wave_pin);
  // compare and count
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", s, e, g);
      err_count++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // bounded wait for the pin enable to reach v
  task automatic wait_oe(input logic v);
    n = 0;
    while (irq_pin_combined_oe !== v && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("oe wait", {7'h0, v}, {7'h0, irq_pin_combined_oe});
  endtask
  // the pin enable must stay at v for c cycles
  task automatic hold(input logic v, input int c, input string s);
    n = 0;
    repeat (c) begin
      @(posedge sys_clk);
      #1 if (irq_pin_combined_oe !== v) n++;
    end
    chk(s, 8'h0, {7'h0, n != 0});
  endtask
  // square-wave edges in 256 cycles, after the new setting settles
  task automatic sqc(input int e, input string s);
    logic p;
    repeat (4) @(posedge sys_clk);
    #1 n = 0;
    p = square_wave_pin;
    repeat (256) begin
      @(posedge sys_clk);
      #1 if (square_wave_pin !== p) n++;
      p = square_wave_pin;
    end
    chk(s, e[7:0], n[7:0]);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    err_count++;
    $display("BAD watchdog exp done got hang");
    stop_test;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(8'h08, 8'h80);
    rdc(8'h0a, 8'h40);
    rdc(8'h11, 8'h03);
    rdc(8'h13, 8'h10);
    rdc(8'h10, 8'h00);
    rdc(8'h20, 8'h00);
    $display("test reset values done");
    host.wr(8'h11, 8'ha0);
    host.wr(8'h10, 8'h02);
    wait_oe(1);
    host.wr(8'h10, 8'h02);
    #1 chk("oe after value write", 8'h1, {7'h0, irq_pin_combined_oe});
    rdc(8'h0f, 8'h08);
    chk("oe after flags read", 8'h0, {7'h0, irq_pin_combined_oe});
    wait_oe(1);
    t0 = cyc;
    host.rd(8'h0f, q);
    wait_oe(1);
    chk("period", 8'd128, 8'(cyc - t0));
    host.wr(8'h11, 8'h80);
    hold(0, 200, "irq disabled");
    $display("test level mode done");
    host.wr(8'h10, 8'h01);
    host.wr(8'h11, 8'he0);
    wait_oe(0);
    wait_oe(1);
    t0 = cyc;
    wait_oe(0);
    chk("pulse width", 8'd32, 8'(cyc - t0));
    rdc(8'h0f, 8'h08);
    wait_oe(1);
    host.wr(8'h08, 8'h00);
    hold(1, 150, "static low in pulse mode");
    host.wr(8'h08, 8'h80);
    alarm1_irq_enable <= 1'b1;
    alarm1_irq_active <= 1'b1;
    hold(1, 150, "alarm source");
    alarm1_irq_enable <= 1'b0;
    alarm1_irq_active <= 1'b0;
    host.wr(8'h11, 8'h03);
    hold(0, 150, "pulses stopped");
    host.wr(8'h10, 8'h00);
    host.rd(8'h0f, q);
    host.wr(8'h11, 8'ha0);
    hold(0, 300, "zero load");
    $display("test pulse mode done");
    sqc(64, "sqw 32k");
    host.wr(8'h13, 8'h30);
    sqc(8, "sqw 4k");
    host.wr(8'h0a, 8'h00);
    sqc(0, "sqw disabled");
    host.wr(8'h0a, 8'h40);
    host.wr(8'h13, 8'h00);
    sqc(0, "sqw none");
    host.wr(8'h13, 8'h10);
    host.wr(8'h11, 8'h80);
    vcc_nominal <= 1'b0;
    battery_ok <= 1'b0;
    sqc(0, "sqw on backup");
    rdc(8'h11, 8'h00);
    rdc(8'h0f, 8'h00);
    vcc_nominal <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rdc(8'h0f, 8'h10);
    battery_ok <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rdc(8'h0f, 8'h10);
    xf <= 4'ha;
    rdc(8'h0f, 8'hb0);
    chk("flags_read strobes", 8'd8, 8'(fr));
    chk("pin drive level", 8'h0, {7'h0, pin_o});
    $display("test square wave and battery done");
    repeat (3) @(posedge sys_clk);
    #1 chk("leap c0", 8'h1, {7'h0, leap_year});
    @(posedge sys_clk);
    century_rollover <= 1'b1;
    @(posedge sys_clk);
    century_rollover <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("century", 8'h1, {6'h0, century_count});
    chk("leap c1", 8'h0, {7'h0, leap_year});
    $display("test century done");
    stop_test;
  end
endmodule
